//--- logic/core_status_and_option_regs.sv
// Purpose: Core status register and write-only prescaler configuration
// Assumes: Instruction decode supplies strobes; one clock
// Notes: Reset cause is presented with a soft reset pulse
`timescale 1ns/100ps
`include "core_regs_params.svh"
module core_status_and_option_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic softReset,
  input wire core_regs_pkg::reset_cause_type resetCause,
  input wire logic [7:0] accumulator,
  input wire logic configLoad,
  input wire logic [4:0] writeAddr,
  input wire logic writeEnable,
  input wire logic [7:0] writeData,
  input wire logic [7:0] operand,
  input wire logic rotate_right_op,
  input wire logic rotate_left_op,
  input wire logic aluCarryUpdate,
  input wire logic aluCarry,
  input wire logic aluNibbleUpdate,
  input wire logic aluNibble,
  input wire logic aluZeroUpdate,
  input wire logic aluZero,
  input wire logic watchdogExpired,
  input wire logic clearWatchdog,
  input wire logic sleepEntered,
  output logic [7:0] statusValue,
  output logic [7:0] prescaleTimerConfig
);
  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  logic statusWrite;
  logic flagUpdate;
  logic flagWrite;
  logic carryUpdate;
  logic carryValue;
  logic wakeCause;
  logic pin_change_wake_flag;
  logic program_page_sel;
  logic watchdog_expiry_n;
  logic sleep_entered_n;
  logic zeroFlag;
  logic nibble_overflow_flag;
  logic carryFlag;

  // ---------------------------------------------
  // Status write decode
  // ---------------------------------------------
  always_comb
  begin
    statusWrite = writeEnable && (writeAddr == `STATUS_ADDR);
  end

  // ---------------------------------------------
  // Carry source
  // ---------------------------------------------
  // Rotates take the bit shifted out and override the adder carry
  always_comb
  begin
    if (rotate_right_op)
      carryValue = operand[`OPERAND_LSB];
    else if (rotate_left_op)
      carryValue = operand[`OPERAND_MSB];
    else
      carryValue = aluCarry;
    carryUpdate = aluCarryUpdate || rotate_right_op || rotate_left_op;
  end

  // ---------------------------------------------
  // Flag write blocking
  // ---------------------------------------------
  // One flag update drops the software write to all three flags, so
  // clearing the status register leaves the two untouched flags alone
  always_comb
  begin
    flagUpdate = aluZeroUpdate || aluNibbleUpdate || carryUpdate;
    flagWrite = statusWrite && !flagUpdate;
  end

  // ---------------------------------------------
  // Reset cause
  // ---------------------------------------------
  always_comb
  begin
    wakeCause = (resetCause == core_regs_pkg::CAUSE_PIN_WAKE);
  end

  // ---------------------------------------------
  // Configuration register
  // ---------------------------------------------
  // Feeds the prescaler only; software has no read path to it
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      prescaleTimerConfig <= `CONFIG_RESET;
    else if (softReset)
      prescaleTimerConfig <= `CONFIG_RESET;
    else if (configLoad)
      prescaleTimerConfig <= accumulator;
  end

  // ---------------------------------------------
  // Pin-change wake flag
  // ---------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      pin_change_wake_flag <= `WAKE_POR;
    else if (softReset)
      pin_change_wake_flag <= wakeCause;
    else if (statusWrite)
      pin_change_wake_flag <= writeData[`BIT_WAKE];
  end

  // ---------------------------------------------
  // Program page select
  // ---------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      program_page_sel <= `PAGE_POR;
    else if (softReset)
      program_page_sel <= `PAGE_POR;
    else if (statusWrite)
      program_page_sel <= writeData[`BIT_PAGE];
  end

  // ---------------------------------------------
  // Timeout flag
  // ---------------------------------------------
  // Hardware events only; an expiry wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      watchdog_expiry_n <= `WDOG_POR;
    else if (watchdogExpired)
      watchdog_expiry_n <= 1'b0;
    else if (clearWatchdog || sleepEntered)
      watchdog_expiry_n <= 1'b1;
  end

  // ---------------------------------------------
  // Power-down flag
  // ---------------------------------------------
  // An expiry cycle leaves this flag as it is
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      sleep_entered_n <= `SLEEP_POR;
    else if (!watchdogExpired && clearWatchdog)
      sleep_entered_n <= 1'b1;
    else if (!watchdogExpired && sleepEntered)
      sleep_entered_n <= 1'b0;
  end

  // ---------------------------------------------
  // Zero flag
  // ---------------------------------------------
  status_flag_bit zeroBit (
    .clock(clock),
    .arst_n(arst_n),
    .aluUpdate(aluZeroUpdate),
    .aluValue(aluZero),
    .swWrite(flagWrite),
    .swValue(writeData[`BIT_ZERO]),
    .flag(zeroFlag)
  );

  // ---------------------------------------------
  // Nibble carry flag
  // ---------------------------------------------
  status_flag_bit nibbleBit (
    .clock(clock),
    .arst_n(arst_n),
    .aluUpdate(aluNibbleUpdate),
    .aluValue(aluNibble),
    .swWrite(flagWrite),
    .swValue(writeData[`BIT_NIBBLE]),
    .flag(nibble_overflow_flag)
  );

  // ---------------------------------------------
  // Carry flag
  // ---------------------------------------------
  status_flag_bit carryBit (
    .clock(clock),
    .arst_n(arst_n),
    .aluUpdate(carryUpdate),
    .aluValue(carryValue),
    .swWrite(flagWrite),
    .swValue(writeData[`BIT_CARRY]),
    .flag(carryFlag)
  );

  // ---------------------------------------------
  // Read view
  // ---------------------------------------------
  always_comb
  begin
    statusValue[`BIT_WAKE] = pin_change_wake_flag;
    // Bit 6 is not built and reads as zero
    statusValue[`BIT_UNUSED] = 1'b0;
    statusValue[`BIT_PAGE] = program_page_sel;
    statusValue[`BIT_WDOG] = watchdog_expiry_n;
    statusValue[`BIT_SLEEP] = sleep_entered_n;
    statusValue[`BIT_ZERO] = zeroFlag;
    statusValue[`BIT_NIBBLE] = nibble_overflow_flag;
    statusValue[`BIT_CARRY] = carryFlag;
  end
endmodule

//--- logic/core_regs_params.svh
// Purpose: Constants for the core status and configuration registers
// Assumes: 8-bit data path
// Notes: Included by the design modules
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH
`define STATUS_ADDR 5'h03
`define BIT_WAKE 7
`define BIT_UNUSED 6
`define BIT_PAGE 5
`define BIT_WDOG 4
`define BIT_SLEEP 3
`define BIT_ZERO 2
`define BIT_NIBBLE 1
`define BIT_CARRY 0
`define CONFIG_RESET 8'hFF
`define STATUS_POR 8'h18
`define WAKE_POR 1'b0
`define PAGE_POR 1'b0
`define WDOG_POR 1'b1
`define SLEEP_POR 1'b1
`define FLAG_POR 1'b0
`define OPERAND_LSB 0
`define OPERAND_MSB 7
`endif

//--- logic/core_regs_pkg.sv
// Purpose: Types for the core status and configuration registers
// Assumes: Nothing beyond the params header
// Notes: Reset cause encoding
package core_regs_pkg;
  typedef enum logic [1:0] {
    CAUSE_POWER_ON = 2'b00,
    CAUSE_EXTERNAL = 2'b01,
    CAUSE_WATCHDOG = 2'b10,
    CAUSE_PIN_WAKE = 2'b11
  } reset_cause_type;
endpackage

//--- logic/status_flag_bit.sv
// Purpose: One arithmetic status flag with write blocking
// Assumes: ALU update takes priority over software write
// Notes: Instantiated for zero, nibble carry and carry
`timescale 1ns/100ps
`include "core_regs_params.svh"
module status_flag_bit (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic aluUpdate,
  input wire logic aluValue,
  input wire logic swWrite,
  input wire logic swValue,
  output logic flag
);
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      flag <= `FLAG_POR;
    else if (aluUpdate)
      flag <= aluValue;
    else if (swWrite)
      flag <= swValue;
  end
endmodule

//--- tb/core_regs_monitor.sv
// Purpose: Port checks for the status and config registers
// Assumes: One clock, async reset
// Notes: Bound to the register block
`timescale 1ns/100ps
module core_regs_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic softReset,
  input wire core_regs_pkg::reset_cause_type resetCause,
  input wire logic [7:0] accumulator,
  input wire logic configLoad,
  input wire logic [4:0] writeAddr,
  input wire logic writeEnable,
  input wire logic [7:0] operand,
  input wire logic rotate_right_op,
  input wire logic rotate_left_op,
  input wire logic aluCarryUpdate,
  input wire logic aluNibbleUpdate,
  input wire logic aluZeroUpdate,
  input wire logic aluZero,
  input wire logic watchdogExpired,
  input wire logic clearWatchdog,
  input wire logic sleepEntered,
  input wire logic [7:0] statusValue,
  input wire logic [7:0] prescaleTimerConfig
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  AST_LOAD: assert property (configLoad && !softReset |=>
    prescaleTimerConfig == $past(accumulator)) else $error("load lost");
  AST_SOFTCFG: assert property (softReset |=>
    prescaleTimerConfig == 8'hFF) else $error("config not set");
  AST_HOLD: assert property (!configLoad && !softReset |=>
    $stable(prescaleTimerConfig)) else $error("config changed");
  AST_RRIGHT: assert property (rotate_right_op |=>
    statusValue[0] == $past(operand[0])) else $error("rotate right");
  AST_RLEFT: assert property (rotate_left_op &&
    !rotate_right_op |=> statusValue[0] == $past(operand[7]))
    else $error("rotate left");
  AST_ZERO: assert property (aluZeroUpdate |=>
    statusValue[2] == $past(aluZero)) else $error("zero flag");
  AST_BLOCK: assert property (aluZeroUpdate && writeEnable &&
    writeAddr == 5'h03 && !aluNibbleUpdate && !aluCarryUpdate &&
    !rotate_right_op && !rotate_left_op |=> $stable(statusValue[1:0]))
    else $error("flag write not blocked");
  AST_FLAGS_RO: assert property (writeEnable && !softReset &&
    !watchdogExpired && !clearWatchdog && !sleepEntered |=>
    $stable(statusValue[4:3])) else $error("flags written");
  AST_WAKE: assert property (softReset |=> statusValue[7] ==
    ($past(resetCause) == core_regs_pkg::CAUSE_PIN_WAKE))
    else $error("wake flag");
  cover property (configLoad);
  cover property (softReset && resetCause == core_regs_pkg::CAUSE_PIN_WAKE);
  cover property (rotate_left_op);
  cover property (writeEnable && writeAddr == 5'h03 && aluZeroUpdate);
endmodule
bind core_status_and_option_regs core_regs_monitor i_mon (.*);

//--- tb/testbench.sv
// Purpose: Self-checking bench for the status and config registers
// Assumes: 125 MHz clock
// Notes: Directed corners, then random strobes
`timescale 1ns/100ps
module testbench;
  logic clock = 0, arst_n = 0, softReset = 0, configLoad = 0;
  logic writeEnable = 0, rotate_right_op = 0, rotate_left_op = 0;
  logic aluCarryUpdate = 0, aluCarry = 0, aluNibbleUpdate = 0;
  logic aluNibble = 0, aluZeroUpdate = 0, aluZero = 0;
  logic watchdogExpired = 0, clearWatchdog = 0, sleepEntered = 0;
  logic [7:0] accumulator = 0, writeData = 0, operand = 0;
  logic [7:0] statusValue, prescaleTimerConfig;
  logic [7:0] ops [4] = '{8'h01, 8'h80, 8'hFE, 8'h7F};
  logic [4:0] writeAddr = 5'h03;
  core_regs_pkg::reset_cause_type resetCause = core_regs_pkg::CAUSE_POWER_ON;
  int error_cnt = 0, total_checks = 0;
  logic [7:0] mCfg, mStat;
  core_status_and_option_regs i_core_status_and_option_regs (.*);
  initial forever #4 clock = ~clock;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic rot_carry(input logic [7:0] op, input logic rr);
    return rr ? op[0] : op[7];
  endfunction
  // Expected configuration after the coming edge
  function automatic logic [7:0] next_config(input logic [7:0] cur);
    if (softReset)
      return 8'hFF;
    if (configLoad)
      return accumulator;
    return cur;
  endfunction
  // Expected status after the coming edge, from the present inputs
  function automatic logic [7:0] next_status(input logic [7:0] cur);
    logic [7:0] s;
    logic flagWr;
    s = cur;
    flagWr = writeEnable && writeAddr == 5'h03 && !aluZeroUpdate &&
      !aluNibbleUpdate && !aluCarryUpdate && !rotate_right_op &&
      !rotate_left_op;
    if (softReset)
    begin
      s[7] = resetCause == core_regs_pkg::CAUSE_PIN_WAKE;
      s[5] = 1'b0;
    end
    else if (writeEnable && writeAddr == 5'h03)
    begin
      s[7] = writeData[7];
      s[5] = writeData[5];
    end
    if (watchdogExpired)
      s[4] = 1'b0;
    else if (clearWatchdog)
      s[4:3] = 2'b11;
    else if (sleepEntered)
      s[4:3] = 2'b10;
    if (aluZeroUpdate)
      s[2] = aluZero;
    else if (flagWr)
      s[2] = writeData[2];
    if (aluNibbleUpdate)
      s[1] = aluNibble;
    else if (flagWr)
      s[1] = writeData[1];
    if (rotate_right_op || rotate_left_op)
      s[0] = rot_carry(operand, rotate_right_op);
    else if (aluCarryUpdate)
      s[0] = aluCarry;
    else if (flagWr)
      s[0] = writeData[0];
    s[6] = 1'b0;
    return s;
  endfunction
  task summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Drop every strobe at the edge that samples it, then settle
  task nxt;
    @(posedge clock);
    {softReset, configLoad, writeEnable, rotate_right_op} <= 4'h0;
    {rotate_left_op, aluZeroUpdate, watchdogExpired} <= 3'h0;
    {clearWatchdog, sleepEntered, aluCarryUpdate, aluNibbleUpdate} <= 4'h0;
    #1;
  endtask
  task wr(input logic [7:0] d, input logic zu);
    @(posedge clock);
    writeData <= d;
    writeEnable <= 1;
    aluZeroUpdate <= zu;
    nxt();
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'hDFACA129));
    repeat (20) @(posedge clock);
    arst_n <= 1;
    nxt();
    chk(prescaleTimerConfig, 8'hFF);
    chk(statusValue, 8'h18);
    wr(8'hFF, 1); // Zero update wins over the write
    chk(statusValue, 8'hB8);
    wr(8'h00, 0);
    chk(statusValue, 8'h18);
    $display("reset and status writes done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      operand <= ops[i];
      rotate_right_op <= !i[0];
      rotate_left_op <= i[0];
      nxt();
      chk(statusValue[0], rot_carry(ops[i], !i[0]));
      @(posedge clock);
      accumulator <= i[1] ? 8'($urandom) : ops[i];
      configLoad <= 1;
      nxt();
      chk(prescaleTimerConfig, accumulator);
      @(posedge clock);
      softReset <= 1;
      resetCause <= core_regs_pkg::reset_cause_type'(i);
      nxt();
      chk(statusValue[7], i == 3);
      chk(prescaleTimerConfig, 8'hFF);
    end
    $display("rotate, load and soft reset done");
    // Mid-run reset brings design and model to one known state
    @(posedge clock);
    arst_n <= 0;
    repeat (2) @(posedge clock);
    arst_n <= 1;
    nxt();
    mCfg = 8'hFF;
    mStat = 8'h18;
    chk(prescaleTimerConfig, mCfg);
    chk(statusValue, mStat);
    $display("mid-run reset done");
    repeat (2000)
    begin
      mCfg = next_config(mCfg);
      mStat = next_status(mStat);
      @(posedge clock);
      {softReset, configLoad, writeEnable} <= 3'($urandom % 8 & $urandom);
      {rotate_right_op, rotate_left_op} <= 2'($urandom);
      {aluCarryUpdate, aluCarry, aluNibbleUpdate, aluNibble} <= 4'($urandom);
      {aluZeroUpdate, aluZero, watchdogExpired} <= 3'($urandom);
      {clearWatchdog, sleepEntered} <= 2'($urandom % 4 & $urandom);
      {accumulator, writeData, operand} <= 24'($urandom);
      writeAddr <= 5'($urandom_range(5, 1));
      resetCause <= core_regs_pkg::reset_cause_type'(2'($urandom));
      #1;
      chk(prescaleTimerConfig, mCfg);
      chk(statusValue, mStat);
    end
    $display("random phase done");
    summarize();
  end
endmodule
